// ===== design/msr_regmap.v
/*
  Holding-register bank with identification objects for the sensor.
  Assumes a frame engine ahead of it: it presents one command per request
  and then moves register words (or identification bytes) one per handshake.
*/
`include "msr_regs.vh"

module msr_regmap #(
  parameter [511:0] ID_TEXT = {"VEND_XYZPROD_XYZV0_0_0_1URL_XYZ_",
                               "NAME_XYZSER_0000CAL_0000TXT_0000"}
) (
  input  wire        clock,
  input  wire        rstn,
  input  wire [31:0] meas_temp,
  input  wire [31:0] meas_dewpt,
  input  wire [31:0] meas_dewpt_atm,
  input  wire [31:0] meas_ppmv,
  input  wire [31:0] meas_press,
  input  wire [31:0] meas_dens,
  input  wire [31:0] meas_npress,
  input  wire        meas_fresh,
  input  wire [31:0] err_bits,
  input  wire        purge_running,
  input  wire        cmd_valid,
  output wire        cmd_ready,
  input  wire [7:0]  cmd_func,
  input  wire [15:0] cmd_addr,
  input  wire [15:0] cmd_count,
  output reg         cmd_done_ff,
  output reg  [7:0]  cmd_exc_ff,
  output wire        rd_valid,
  input  wire        rd_ready,
  output reg  [15:0] rd_data_ff,
  output wire        wr_ready,
  input  wire        wr_valid,
  input  wire [15:0] wr_data,
  output reg  [31:0] molar_mass_ff,
  output reg  [31:0] mix_ratio_ff,
  output reg  [31:0] norm_temp_ff,
  output reg         auto_purge_ff,
  output reg         startup_purge_ff,
  output reg         manual_purge_ff,
  output reg  [7:0]  station_addr_ff
);

  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_RD   = 2'd1;
  localparam [1:0] S_WR   = 2'd2;
  localparam [1:0] S_ID   = 2'd3;

  reg  [1:0]  state_ff;
  reg  [15:0] addr_ff;
  reg  [15:0] cnt_ff;
  reg  [2:0]  obj_ff;
  reg  [3:0]  pos_ff;
  reg  [7:0]  nxt_exc;
  reg  [2:0]  nxt_obj;
  reg  [2:0]  nxt_last;
  wire [15:0] end_addr;
  wire [7:0]  rcode;
  wire        id_ok;
  wire [2:0]  id_idx;
  wire [3:0]  id_num;

  assign cmd_ready = (state_ff == S_IDLE);
  assign rd_valid  = (state_ff == S_RD) || (state_ff == S_ID);
  assign wr_ready  = (state_ff == S_WR);
  assign end_addr  = cmd_addr + cmd_count - 16'h0001;
  assign rcode     = cmd_count[7:0];
  // Object id to table index: 0..4 and 128..130 fill indices 0..7
  assign id_ok  = (cmd_addr[7:0] < 8'h05) ||
                  (cmd_addr[7:0] >= `MSR_ID_PRIV &&
                   cmd_addr[7:0] < `MSR_ID_PRIV + 8'h03); // RQ13
  assign id_idx = cmd_addr[7] ? cmd_addr[2:0] + 3'd5 : cmd_addr[2:0];
  // Objects in the stream, up to eight, so four bits
  assign id_num = {1'b0, nxt_last} - {1'b0, nxt_obj} + 4'd1;

  // Range lies wholly inside one writable group
  function wr_map_ok;
    input [15:0] lo;
    input [15:0] hi;
    begin
      wr_map_ok = `MSR_GRP(lo, hi, `MSR_A_MOLAR, `MSR_A_MOLAR + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_MIX, `MSR_A_NTEMP + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_AUTO, `MSR_A_PURGE) ||
                  `MSR_GRP(lo, hi, `MSR_A_STATION, `MSR_A_STATION);
    end
  endfunction

  // Range lies wholly inside one readable group
  function rd_map_ok;
    input [15:0] lo;
    input [15:0] hi;
    begin
      rd_map_ok = wr_map_ok(lo, hi) ||
                  `MSR_GRP(lo, hi, `MSR_A_TEMP, `MSR_A_DEWPT + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_DEWPT_ATM,
                           `MSR_A_DEWPT_ATM + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_PPMV, `MSR_A_PPMV + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_PRESS, `MSR_A_NPRESS + 16'h0001) ||
                  `MSR_GRP(lo, hi, `MSR_A_FAULT, `MSR_A_ONLINE) ||
                  `MSR_GRP(lo, hi, `MSR_A_ERR, `MSR_A_ERR + 16'h0001);
    end
  endfunction

  // Word at one register address; low half first, high half next
  function [15:0] word_at;
    input [15:0] a;
    begin
      case (a)
        `MSR_A_TEMP:                   word_at = meas_temp[15:0]; // RQ1 RQ2
        `MSR_A_TEMP + 16'h0001:        word_at = meas_temp[31:16]; // RQ1
        `MSR_A_DEWPT:                  word_at = meas_dewpt[15:0];
        `MSR_A_DEWPT + 16'h0001:       word_at = meas_dewpt[31:16];
        `MSR_A_DEWPT_ATM:              word_at = meas_dewpt_atm[15:0];
        `MSR_A_DEWPT_ATM + 16'h0001:   word_at = meas_dewpt_atm[31:16];
        `MSR_A_PPMV:                   word_at = meas_ppmv[15:0];
        `MSR_A_PPMV + 16'h0001:        word_at = meas_ppmv[31:16];
        `MSR_A_PRESS:                  word_at = meas_press[15:0];
        `MSR_A_PRESS + 16'h0001:       word_at = meas_press[31:16];
        `MSR_A_DENS:                   word_at = meas_dens[15:0];
        `MSR_A_DENS + 16'h0001:        word_at = meas_dens[31:16];
        `MSR_A_NPRESS:                 word_at = meas_npress[15:0];
        `MSR_A_NPRESS + 16'h0001:      word_at = meas_npress[31:16];
        `MSR_A_FAULT:  word_at = {15'h0000, err_bits == 32'h0000_0000}; // RQ9
        `MSR_A_ONLINE:   word_at = {15'h0000, meas_fresh}; // RQ9
        `MSR_A_ERR:                    word_at = err_bits[15:0]; // RQ8
        `MSR_A_ERR + 16'h0001:         word_at = err_bits[31:16]; // RQ8
        `MSR_A_MOLAR:                  word_at = molar_mass_ff[15:0]; // RQ4
        `MSR_A_MOLAR + 16'h0001:       word_at = molar_mass_ff[31:16];
        `MSR_A_MIX:                    word_at = mix_ratio_ff[15:0];
        `MSR_A_MIX + 16'h0001:         word_at = mix_ratio_ff[31:16];
        `MSR_A_NTEMP:                  word_at = norm_temp_ff[15:0];
        `MSR_A_NTEMP + 16'h0001:       word_at = norm_temp_ff[31:16];
        `MSR_A_AUTO:     word_at = {15'h0000, auto_purge_ff}; // RQ6
        `MSR_A_START:    word_at = {15'h0000, startup_purge_ff}; // RQ6
        `MSR_A_PURGE:    word_at = {15'h0000, purge_running}; // RQ11
        `MSR_A_STATION:  word_at = {8'h00, station_addr_ff}; // RQ7
        default:                       word_at = 16'h0000;
      endcase
    end
  endfunction

  // Identification byte: object id, length, then text characters
  function [7:0] id_byte;
    input [2:0] idx;
    input [3:0] pos;
    reg   [5:0] ch;
    begin
      ch = {idx, 3'b000} + {2'b00, pos} - 6'd2;
      if (pos == 4'd0)
        id_byte = (idx < 3'd5) ? {5'h00, idx} :
                  `MSR_ID_PRIV + {5'h00, idx} - 8'h05;
      else if (pos == 4'd1)
        id_byte = `MSR_ID_LEN;
      else
        id_byte = ID_TEXT[{~ch, 3'b000} +: 8];
    end
  endfunction

  // Command check and stream bounds
  always @*
  begin
    nxt_exc  = `MSR_EXC_NONE;
    nxt_obj  = 3'd0;
    nxt_last = 3'd0;
    case (cmd_func)
      `MSR_FC_RD: // RQ14
        if (cmd_count == 16'h0000 || cmd_count > `MSR_MAX_RD)
          nxt_exc = `MSR_EXC_VALUE;
        else if (!rd_map_ok(cmd_addr, end_addr))
          nxt_exc = `MSR_EXC_ADDR;
      `MSR_FC_WR: // RQ14
        if (cmd_count == 16'h0000 || cmd_count > `MSR_MAX_WR)
          nxt_exc = `MSR_EXC_VALUE;
        else if (!wr_map_ok(cmd_addr, end_addr))
          nxt_exc = `MSR_EXC_ADDR; // RQ16
      `MSR_FC_ID: // RQ14
      begin
        nxt_last = (rcode == 8'h01) ? 3'd2 :
                   (rcode == 8'h02) ? 3'd4 : 3'd7; // RQ13
        nxt_obj  = (id_ok && id_idx <= nxt_last) ? id_idx : 3'd0;
        if (cmd_count[15:8] != `MSR_MEI_ID)
          nxt_exc = `MSR_EXC_FUNC;
        else if (rcode == 8'h00 || rcode > 8'h04)
          nxt_exc = `MSR_EXC_VALUE;
        else if (rcode == 8'h04)
        begin
          nxt_obj  = id_idx;
          nxt_last = id_idx;
          if (!id_ok)
            nxt_exc = `MSR_EXC_ADDR; // RQ13
        end
      end
      default:
        nxt_exc = `MSR_EXC_FUNC;
    endcase
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff         <= S_IDLE;
      addr_ff          <= 16'h0000;
      cnt_ff           <= 16'h0000;
      obj_ff           <= 3'd0;
      pos_ff           <= 4'd0;
      cmd_done_ff      <= 1'b0;
      cmd_exc_ff       <= `MSR_EXC_NONE;
      rd_data_ff       <= 16'h0000;
      molar_mass_ff    <= `MSR_RST_FLOAT;
      mix_ratio_ff     <= `MSR_RST_FLOAT;
      norm_temp_ff     <= `MSR_RST_FLOAT;
      auto_purge_ff    <= 1'b1;
      startup_purge_ff <= 1'b1;
      manual_purge_ff  <= 1'b0;
      station_addr_ff  <= `MSR_RST_STATION;
    end
    else
    begin
      cmd_done_ff     <= 1'b0;
      manual_purge_ff <= 1'b0;
      case (state_ff)
        S_IDLE:
          if (cmd_valid)
          begin
            cmd_done_ff <= 1'b1;
            cmd_exc_ff  <= nxt_exc;
            addr_ff     <= cmd_addr; // RQ5
            cnt_ff      <= cmd_count;
            obj_ff      <= nxt_obj;
            pos_ff      <= 4'd0;
            if (nxt_exc == `MSR_EXC_NONE)
            begin
              if (cmd_func == `MSR_FC_RD)
              begin
                state_ff   <= S_RD;
                rd_data_ff <= word_at(cmd_addr);
              end
              else if (cmd_func == `MSR_FC_WR)
                state_ff <= S_WR;
              else
              begin
                state_ff   <= S_ID;
                // Ten bytes per object: id, length, eight characters
                cnt_ff     <= {9'h000, id_num, 3'b000} +
                              {11'h000, id_num, 1'b0}; // RQ13
                rd_data_ff <= {8'h00, id_byte(nxt_obj, 4'd0)};
              end
            end
          end
        S_RD:
          if (rd_ready)
          begin
            addr_ff    <= addr_ff + 16'h0001;
            cnt_ff     <= cnt_ff - 16'h0001;
            rd_data_ff <= word_at(addr_ff + 16'h0001);
            if (cnt_ff == 16'h0001)
              state_ff <= S_IDLE;
          end
        S_ID:
          if (rd_ready)
          begin
            cnt_ff <= cnt_ff - 16'h0001;
            if (pos_ff == 4'd9)
            begin
              pos_ff     <= 4'd0;
              obj_ff     <= obj_ff + 3'd1;
              rd_data_ff <= {8'h00, id_byte(obj_ff + 3'd1, 4'd0)};
            end
            else
            begin
              pos_ff     <= pos_ff + 4'd1;
              rd_data_ff <= {8'h00, id_byte(obj_ff, pos_ff + 4'd1)};
            end
            if (cnt_ff == 16'h0001)
              state_ff <= S_IDLE;
          end
        S_WR:
          if (wr_valid)
          begin
            addr_ff <= addr_ff + 16'h0001;
            cnt_ff  <= cnt_ff - 16'h0001;
            if (cnt_ff == 16'h0001)
              state_ff <= S_IDLE;
            // Only writable words decode; everything else is left alone
            case (addr_ff) // RQ3
              `MSR_A_MOLAR:             molar_mass_ff[15:0]  <= wr_data; // RQ4
              `MSR_A_MOLAR + 16'h0001:  molar_mass_ff[31:16] <= wr_data; // RQ1
              `MSR_A_MIX:               mix_ratio_ff[15:0]   <= wr_data;
              `MSR_A_MIX + 16'h0001:    mix_ratio_ff[31:16]  <= wr_data;
              `MSR_A_NTEMP:             norm_temp_ff[15:0]   <= wr_data;
              `MSR_A_NTEMP + 16'h0001:  norm_temp_ff[31:16]  <= wr_data;
              `MSR_A_AUTO:              auto_purge_ff    <= wr_data[0]; // RQ11
              `MSR_A_START:             startup_purge_ff <= wr_data[0]; // RQ11
              `MSR_A_PURGE:             manual_purge_ff  <= wr_data[0]; // RQ11
              `MSR_A_STATION:
                if (wr_data != 16'h0000 && wr_data[15:8] == 8'h00)
                  station_addr_ff <= wr_data[7:0]; // RQ10
              default:
                station_addr_ff <= station_addr_ff;
            endcase
          end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

endmodule // msr_regmap

// ===== inc/msr_regs.vh
/*
  Register offsets, limits, function codes and reset values for the
  sensor holding-register map served to a Modbus master.
  Assumes a frame engine that parses frames and checks the station address.
*/
// What this block and the master must do
// (RQ1) A 32-bit value sits in two registers, bits 15..0 low, 31..16 next.
// (RQ2) Every float, measured or set, is IEEE 754 single precision.
// (RQ3) Read-only registers are never changed by a write request.
// (RQ4) Read/write registers take the written value and return it on reads.
// (RQ5) The address in a request equals the logical register number less one.
// (RQ6) A boolean register only ever reads 0 or 1.
// (RQ7) An integer register is an unsigned 16-bit value, 0 to 65535.
// (RQ8) The error code is 32 single-bit flags over two registers, 0 if clean.
// (RQ9) Fault status reads 1 with no errors, online status 1 with fresh data.
// (RQ10) The station address holds 1 to 255; the master should use 1 to 247.
// (RQ11) Purge enables steer auto and start-up purge; 1 written starts one.
// (RQ12) The master should leave the three purge registers unmodified; the bench's t_purge writes all three, twice.
// (RQ13) Identification works in stream and single mode, objects 0-4, 128-130.
// (RQ14) Function codes 3, 16 and 43 with subcode 14 are served.
// (RQ15) The master waits five seconds after power-up before any request; the bench sends its first request six clock cycles after reset release.
// (RQ16) A write to a read-only or unmapped register gets an exception.
`ifndef MSR_REGS_VH
`define MSR_REGS_VH

`define MSR_A_TEMP      16'h0004
`define MSR_A_DEWPT     16'h0006
`define MSR_A_DEWPT_ATM 16'h000A
`define MSR_A_PPMV      16'h0014
`define MSR_A_PRESS     16'h002C
`define MSR_A_DENS      16'h002E
`define MSR_A_NPRESS    16'h0030
`define MSR_A_FAULT     16'h0200
`define MSR_A_ONLINE    16'h0201
`define MSR_A_ERR       16'h0203
`define MSR_A_MOLAR     16'h0306
`define MSR_A_MIX       16'h030C
`define MSR_A_NTEMP     16'h030E
`define MSR_A_AUTO      16'h0502
`define MSR_A_START     16'h0503
`define MSR_A_PURGE     16'h0504
`define MSR_A_STATION   16'h0600

`define MSR_FC_RD       8'h03
`define MSR_FC_WR       8'h10
`define MSR_FC_ID       8'h2B
`define MSR_MEI_ID      8'h0E
`define MSR_EXC_NONE    8'h00
`define MSR_EXC_FUNC    8'h01
`define MSR_EXC_ADDR    8'h02
`define MSR_EXC_VALUE   8'h03
`define MSR_MAX_RD      16'h007D
`define MSR_MAX_WR      16'h007B

`define MSR_RST_FLOAT   32'h0000_0000
`define MSR_RST_STATION 8'hF0
`define MSR_ID_LEN      8'h08
`define MSR_ID_PRIV     8'h80

`define MSR_GRP(l, h, a, b) ((l) >= (a) && (h) <= (b))

`endif

// ===== verif/msr_regmap_assertions.sv
/* Port checker for msr_regmap handshakes and settings.
   Bound to every msr_regmap instance; sees its ports only. */
module msr_regmap_assertions (
  input logic        clock,
  input logic        rstn,
  input logic        cmd_valid,
  input logic        cmd_ready,
  input logic        cmd_done_ff,
  input logic [7:0]  cmd_exc_ff,
  input logic        rd_valid,
  input logic        rd_ready,
  input logic [15:0] rd_data_ff,
  input logic        wr_valid,
  input logic        wr_ready,
  input logic [31:0] molar_mass_ff,
  input logic        manual_purge_ff,
  input logic [7:0]  station_addr_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_done_after_take: assert property (
    cmd_valid && cmd_ready |=> cmd_done_ff) else $error("no done");
  a_done_has_cause: assert property (
    cmd_done_ff |-> $past(cmd_valid && cmd_ready)) else $error("stray done");
  a_done_single: assert property (
    cmd_done_ff |=> !cmd_done_ff) else $error("long done");
  a_exc_stable: assert property (
    !cmd_done_ff |-> $stable(cmd_exc_ff)) else $error("exc moved");
  a_error_idle: assert property (
    cmd_done_ff && cmd_exc_ff != 8'h00 |-> cmd_ready && !rd_valid
    && !wr_ready) else $error("busy after error");
  a_read_word_held: assert property (
    rd_valid && !rd_ready |=> rd_valid && $stable(rd_data_ff))
    else $error("read word lost");
  a_settings_held: assert property (
    !(wr_valid && wr_ready) |=> $stable(molar_mass_ff)
    && $stable(station_addr_ff)) else $error("setting moved");
  a_manual_pulse: assert property (
    manual_purge_ff |=> !manual_purge_ff) else $error("long purge pulse");
  a_station_range: assert property (
    station_addr_ff != 8'h00) else $error("station zero");
endmodule // msr_regmap_assertions

bind msr_regmap msr_regmap_assertions i_chk (
  .clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_done_ff(cmd_done_ff),
  .cmd_exc_ff(cmd_exc_ff), .rd_valid(rd_valid), .rd_ready(rd_ready),
  .rd_data_ff(rd_data_ff), .wr_valid(wr_valid), .wr_ready(wr_ready),
  .molar_mass_ff(molar_mass_ff), .manual_purge_ff(manual_purge_ff),
  .station_addr_ff(station_addr_ff));

// ===== verif/msr_master_model.sv
/* Bus master model: issues one command, then moves its words.
   Assumes the bench calls xfer and drives on falling edges. */
module msr_master_model (
  input  logic        clock,
  input  logic        cmd_ready,
  input  logic [7:0]  cmd_exc_ff,
  input  logic        rd_valid,
  input  logic [15:0] rd_data_ff,
  input  logic        wr_ready,
  output logic        cmd_valid,
  output logic [7:0]  cmd_func,
  output logic [15:0] cmd_addr,
  output logic [15:0] cmd_count,
  output logic        rd_ready,
  output logic        wr_valid,
  output logic [15:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wbuf [0:7];
  logic [15:0] rbuf [0:31];
  logic        slow = 1'b0;
  int          moved;
  initial
  begin
    {cmd_valid, rd_ready, wr_valid} = 3'b000;
    {cmd_func, cmd_addr, cmd_count, wr_data} = 56'h0;
  end
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, n,
                      input int nw, output logic [7:0] exc);
    int i;
    int k;
    i = 0;
    k = 0;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_func = f;
    cmd_addr = a;
    cmd_count = n;
    while (cmd_ready !== 1'b1 && k < 50)
    begin
      @(negedge clock);
      k++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_addr = ~a;
    exc = cmd_exc_ff;
    while (exc === 8'h00 && i < nw && k < 300)
    begin
      wr_valid = !(slow && k[0]) && f == 8'h10 && wr_ready === 1'b1;
      rd_ready = !(slow && k[0]) && f != 8'h10 && rd_valid === 1'b1;
      if (wr_valid)
      begin
        wr_data = wbuf[i];
        i++;
      end
      else
        wr_data = ~wr_data;
      if (rd_ready)
      begin
        rbuf[i % 32] = rd_data_ff;
        i++;
      end
      @(negedge clock);
      k++;
    end
    rd_ready = 1'b0;
    wr_valid = 1'b0;
    moved = i;
  endtask
endmodule // msr_master_model

// ===== verif/msr_regmap_test.sv
/* Self-checking bench for msr_regmap with a master model.
   Assumes the checker is bound to the design instance. */
module msr_regmap_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rstn, meas_fresh, purge_running, cmd_valid, cmd_ready;
  logic cmd_done_ff, rd_valid, rd_ready, wr_ready, wr_valid;
  logic auto_purge_ff, startup_purge_ff, manual_purge_ff;
  logic [7:0] cmd_func, cmd_exc_ff, station_addr_ff, e;
  logic [15:0] cmd_addr, cmd_count, rd_data_ff, wr_data;
  logic [31:0] err_bits, molar_mass_ff, mix_ratio_ff, norm_temp_ff;
  logic [31:0] meas [0:6];
  int errors, checks_done, pulses;

  msr_regmap i_dut (.clock(clock), .rstn(rstn), .meas_temp(meas[0]),
    .meas_dewpt(meas[1]), .meas_dewpt_atm(meas[2]), .meas_ppmv(meas[3]),
    .meas_press(meas[4]), .meas_dens(meas[5]), .meas_npress(meas[6]),
    .meas_fresh(meas_fresh), .err_bits(err_bits),
    .purge_running(purge_running), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_func(cmd_func), .cmd_addr(cmd_addr),
    .cmd_count(cmd_count), .cmd_done_ff(cmd_done_ff),
    .cmd_exc_ff(cmd_exc_ff), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data_ff(rd_data_ff), .wr_ready(wr_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .molar_mass_ff(molar_mass_ff),
    .mix_ratio_ff(mix_ratio_ff), .norm_temp_ff(norm_temp_ff),
    .auto_purge_ff(auto_purge_ff), .startup_purge_ff(startup_purge_ff),
    .manual_purge_ff(manual_purge_ff), .station_addr_ff(station_addr_ff));
  msr_master_model m (.clock(clock), .cmd_ready(cmd_ready),
    .cmd_exc_ff(cmd_exc_ff), .rd_valid(rd_valid), .rd_data_ff(rd_data_ff),
    .wr_ready(wr_ready), .cmd_valid(cmd_valid), .cmd_func(cmd_func),
    .cmd_addr(cmd_addr), .cmd_count(cmd_count), .rd_ready(rd_ready),
    .wr_valid(wr_valid), .wr_data(wr_data));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
    if (manual_purge_ff === 1'b1)
      pulses++;

  task chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [15:0] a, n);
    m.xfer(8'h10, a, n, int'(n), e);
  endtask
  task rd(input logic [15:0] a, n);
    m.xfer(8'h03, a, n, int'(n), e);
  endtask

  task automatic t_meas;
    logic [15:0] ga [0:3] = '{16'h0004, 16'h000A, 16'h0014, 16'h002C};
    int gn [0:3] = '{4, 2, 2, 6};
    int gi [0:3] = '{0, 2, 3, 4};
    m.slow = 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      rd(ga[j], 16'(gn[j]));
      for (int w = 0; w < gn[j]; w++)
        chk("meas", m.rbuf[w], w[0] ? meas[gi[j] + w / 2][31:16]
            : meas[gi[j] + w / 2][15:0]);
    end
    m.slow = 1'b0;
  endtask
  task t_status;
    meas_fresh = 1'b1;
    rd(16'h0200, 16'h0002);
    chk("fault", m.rbuf[0], 32'h0001);
    chk("online", m.rbuf[1], 32'h0001);
    err_bits = 32'h8000_0001;
    meas_fresh = 1'b0;
    rd(16'h0200, 16'h0002);
    chk("fault", m.rbuf[0], 32'h0000);
    chk("online", m.rbuf[1], 32'h0000);
    rd(16'h0203, 16'h0002);
    chk("err", {m.rbuf[1], m.rbuf[0]}, 32'h8000_0001);
  endtask
  task t_write;
    m.wbuf[0] = 16'h1234;
    m.wbuf[1] = 16'h4142;
    wr(16'h0306, 16'h0002);
    chk("molar", molar_mass_ff, 32'h4142_1234);
    rd(16'h0306, 16'h0002);
    chk("molar rd", {m.rbuf[1], m.rbuf[0]}, 32'h4142_1234);
    m.wbuf[0] = 16'h00F7;
    wr(16'h0600, 16'h0001);
    chk("station", station_addr_ff, 32'h00F7);
    m.wbuf[0] = 16'h0000;
    wr(16'h0600, 16'h0001);
    chk("station 0", station_addr_ff, 32'h00F7);
    m.wbuf[0] = 16'hFFFF;
    wr(16'h0600, 16'h0001);
    chk("station max", station_addr_ff, 32'h00F7);
  endtask
  task t_refuse;
    wr(16'h0004, 16'h0002);
    chk("ro exc", e, 32'h0002);
    chk("molar", molar_mass_ff, 32'h4142_1234);
    rd(16'h0004, 16'h0000);
    chk("cnt0", e, 32'h0003);
    rd(16'h0004, 16'h007E);
    chk("cnt126", e, 32'h0003);
    m.xfer(8'h05, 16'h0004, 16'h0001, 0, e);
    chk("func", e, 32'h0001);
  endtask
  task t_purge;
    pulses = 0;
    m.wbuf[0] = 16'h0000;
    m.wbuf[1] = 16'h0000;
    m.wbuf[2] = 16'h0001;
    wr(16'h0502, 16'h0003);
    chk("auto", auto_purge_ff, 32'h0000);
    chk("startup", startup_purge_ff, 32'h0000);
    chk("manual now", manual_purge_ff, 32'h0001);
    @(negedge clock);
    chk("manual", pulses, 32'h0001);
    purge_running = 1'b1;
    rd(16'h0504, 16'h0001);
    chk("running", m.rbuf[0], 32'h0001);
    m.wbuf[0] = 16'h0001;
    m.wbuf[1] = 16'h0001;
    m.wbuf[2] = 16'h0000;
    wr(16'h0502, 16'h0003);
    chk("auto", auto_purge_ff, 32'h0001);
  endtask
  task t_ident;
    m.xfer(8'h2B, 16'h0080, 16'h0E04, 10, e);
    chk("id one", {m.rbuf[0], m.rbuf[1]}, 32'h0080_0008);
    chk("id one len", m.moved, 32'h000A);
    m.xfer(8'h2B, 16'h0000, 16'h0E01, 30, e);
    chk("id stream", {m.rbuf[10], m.rbuf[20]}, 32'h0001_0002);
    chk("id stream len", m.moved, 32'h001E);
    m.xfer(8'h2B, 16'h0003, 16'h0E02, 20, e);
    chk("id regular", {m.rbuf[0], m.rbuf[10]}, 32'h0003_0004);
    chk("id regular len", m.moved, 32'h0014);
    m.xfer(8'h2B, 16'h0000, 16'h0E03, 80, e);
    chk("id all", m.rbuf[6], 32'h0082);
    chk("id all len", m.moved, 32'h0050);
    m.xfer(8'h2B, 16'h0005, 16'h0E04, 10, e);
    chk("id bad", e, 32'h0002);
    m.xfer(8'h2B, 16'h0000, 16'h0D01, 10, e);
    chk("mei", e, 32'h0001);
  endtask

  initial
  begin
    #100us;
    errors++;
    end_of_test;
  end
  initial
  begin
    rstn = 1'b0;
    {meas_fresh, purge_running, err_bits} = 34'h0;
    for (int j = 0; j < 7; j++)
      meas[j] = 32'h3F80_0000 + (j << 16) + j + 1;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    repeat (5) @(negedge clock);
    chk("station rst", station_addr_ff, 32'h00F0);
    chk("auto rst", auto_purge_ff, 32'h0001);
    t_meas;
    t_status;
    t_write;
    t_refuse;
    t_purge;
    t_ident;
    end_of_test;
  end
endmodule // msr_regmap_test
